/* File: hdl/gto_pkg.sv */
// Purpose: Shared constants and types for the GPIB talker output engine.
// Assumes: 10 MHz core clock.
// Notes: Terminator and end-signal override codes use a 16-bit signed form.
package gto_pkg;
	localparam int CLK_HZ = 10_000_000;
	localparam logic [1:0] MODE_DMA_BIT = 2'h0;
	localparam logic [1:0] MODE_CONT_BIT = 2'h1;
	localparam logic [15:0] OVR_DEFAULT = 16'hFFFF;
	localparam logic [15:0] EOI_NEVER = 16'h0000;
	localparam logic [15:0] EOI_ALWAYS = 16'h0001;
	localparam int MAX_TARGETS = 15;
	localparam logic [4:0] TGT_CNT_W = 5'h4;
	localparam int TIMEOUT_US = 1000;
	localparam int TIMEOUT_CYC = TIMEOUT_US * (CLK_HZ / 1_000_000);
	localparam logic [7:0] CMD_TALK_BASE = 8'h40;
	localparam logic [7:0] CMD_LISTEN_BASE = 8'h20;
	localparam logic [7:0] CMD_SEC_BASE = 8'h60;
	localparam logic [7:0] ERR_NONE = 8'h00;
	localparam logic [7:0] ERR_TIMEOUT = 8'h01;
	localparam logic [7:0] ERR_HALTED = 8'h02;
	localparam logic [7:0] ERR_BAD_COUNT = 8'h03;
	typedef enum logic [2:0] {
		GTO_IDLE = 3'h0,
		GTO_ADDR = 3'h1,
		GTO_DATA = 3'h3,
		GTO_TERM = 3'h2,
		GTO_DONE = 3'h6
	} gto_state_t;
endpackage

/* File: hdl/gto_fifo.sv */
// Purpose: Data FIFO between the host data source and the bus talker.
// Assumes: Single clock; write and read handshakes are valid and ready.
// Notes: Full and empty are exact; the reader can stall and the FIFO fills.
module gto_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic flush,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [AW:0] wp;
		logic [AW:0] rp;
	} gto_fifo_st_t;
	gto_fifo_st_t st, next_st;
	logic [WIDTH-1:0] mem [DEPTH];
	logic push, pop;
	assign in_ready = (st.wp - st.rp) != (AW+1)'(DEPTH);
	assign out_valid = st.wp != st.rp;
	assign out_data = mem[st.rp[AW-1:0]];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	always_comb begin
		next_st = st;
		if (flush) begin
			next_st.wp = '0;
			next_st.rp = '0;
		end else begin
			if (push)
				next_st.wp = st.wp + 1'b1;
			if (pop)
				next_st.rp = st.rp + 1'b1;
		end
	end
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			st <= '0;
		else
			st <= next_st;
	end
	// The storage itself has no reset, so it maps onto plain RAM.
	always_ff @(posedge core_clk) begin
		if (push && !flush)
			mem[st.wp[AW-1:0]] <= in_data;
	end
endmodule

/* File: hdl/gto_engine.sv */
// Purpose: Talker output engine that sends a counted byte block onto the GPIB bus.
// Assumes: Bus pins arrive from outside the clock domain and are synchronised here.
// Notes: The three-wire handshake is run as source; ATN marks command bytes.
module gto_engine #(
	parameter int TIMEOUT_CYCLES = gto_pkg::TIMEOUT_CYC,
	parameter int FIFO_DEPTH = 32
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic start,
	input wire logic [1:0] mode,
	input wire logic [31:0] byte_count,
	input wire logic dma_auto_reload,
	input wire logic halt_transfer_call,
	input wire logic timeout_enable,
	input wire logic is_active_ctl,
	input wire logic is_system_ctl,
	input wire logic skip_addressing,
	input wire logic [4:0] my_address,
	input wire logic [3:0] target_count,
	input wire logic [15:0] target_list [15],
	input wire logic [15:0] eoi_override,
	input wire logic [15:0] term1_override,
	input wire logic [15:0] term2_override,
	input wire logic def_eoi,
	input wire logic [1:0] def_term_num,
	input wire logic [7:0] def_term1,
	input wire logic [7:0] def_term2,
	input wire logic data_valid,
	output logic data_ready,
	input wire logic [7:0] data_in,
	output logic busy,
	output logic host_release,
	output logic done,
	output logic [7:0] status,
	output logic [7:0] dio_out,
	output logic dio_oe,
	output logic dav_out,
	output logic eoi_out,
	output logic atn_out,
	output logic ren_out,
	input wire logic nrfd_in,
	input wire logic ndac_in
);
	typedef struct packed {
		gto_pkg::gto_state_t fsm;
		logic [31:0] left;
		logic [31:0] total;
		logic [4:0] tgt_idx;
		logic sec_phase;
		logic talk_sent;
		logic [1:0] term_left;
		logic [7:0] t1;
		logic [7:0] t2;
		logic use_eoi;
		logic cont;
		logic reload;
		logic [31:0] tmo;
		logic released;
		logic [7:0] dio;
		logic dav;
		logic eoi;
		logic atn;
		logic ren;
		logic done;
		logic [7:0] status;
		logic [1:0] nrfd_s;
		logic [1:0] ndac_s;
	} gto_st_t;
	gto_st_t st, next_st;
	logic [7:0] fifo_data;
	logic fifo_valid, fifo_pop;
	logic busy_st, term1_def;
	logic [7:0] send_byte;
	logic send_ok, send_last, need_byte;
	// Marks a handshake step in this cycle, so the listener timeout restarts from zero.
	logic hs_step;
	gto_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.flush(st.fsm == gto_pkg::GTO_IDLE && start),
		.in_valid(data_valid),
		.in_ready(data_ready),
		.in_data(data_in),
		.out_valid(fifo_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_data)
	);
	assign busy_st = st.fsm != gto_pkg::GTO_IDLE && st.fsm != gto_pkg::GTO_DONE;
	assign busy = busy_st;
	assign host_release = st.released;
	assign done = st.done;
	assign status = st.status;
	assign dio_out = st.dio;
	assign dio_oe = busy_st;
	assign dav_out = st.dav;
	assign eoi_out = st.eoi;
	assign atn_out = st.atn;
	assign ren_out = st.ren;
	assign term1_def = term1_override == gto_pkg::OVR_DEFAULT;
	assign fifo_pop = st.fsm == gto_pkg::GTO_DATA && !st.dav
		&& st.nrfd_s[1] == 1'b0 && fifo_valid;
	// Next byte to place on the bus and whether it closes the message.
	always_comb begin
		send_byte = fifo_data;
		send_ok = 1'b0;
		send_last = 1'b0;
		need_byte = 1'b0;
		if (st.fsm == gto_pkg::GTO_ADDR) begin
			send_ok = 1'b1;
			if (!st.talk_sent)
				send_byte = gto_pkg::CMD_TALK_BASE | {3'h0, my_address};
			else if (st.sec_phase)
				send_byte = gto_pkg::CMD_SEC_BASE | {3'h0, target_list[st.tgt_idx[3:0]][12:8]};
			else
				send_byte = gto_pkg::CMD_LISTEN_BASE | {3'h0, target_list[st.tgt_idx[3:0]][4:0]};
		end else if (st.fsm == gto_pkg::GTO_DATA) begin
			send_ok = fifo_valid;
			send_last = st.left == 32'h1 && st.term_left == 2'h0 && !st.reload;
			need_byte = 1'b1;
		end else if (st.fsm == gto_pkg::GTO_TERM) begin
			send_ok = 1'b1;
			send_byte = st.term_left == 2'h2 ? st.t1 : st.t2;
			send_last = st.term_left == 2'h1;
		end
	end
	always_comb begin
		hs_step = 1'b0;
		next_st = st;
		next_st.nrfd_s = {st.nrfd_s[0], nrfd_in};
		next_st.ndac_s = {st.ndac_s[0], ndac_in};
		next_st.done = 1'b0;
		case (st.fsm)
			gto_pkg::GTO_IDLE, gto_pkg::GTO_DONE: begin
				next_st.fsm = gto_pkg::GTO_IDLE;
				if (start) begin
					next_st.left = byte_count;
					next_st.total = byte_count;
					next_st.cont = mode[gto_pkg::MODE_CONT_BIT[0]];
					next_st.reload = mode[gto_pkg::MODE_DMA_BIT[0]] && mode[gto_pkg::MODE_CONT_BIT[0]]
						&& dma_auto_reload;
					next_st.released = 1'b0;
					next_st.tgt_idx = '0;
					next_st.sec_phase = 1'b0;
					next_st.talk_sent = 1'b0;
					next_st.tmo = '0;
					next_st.ren = 1'b0;
					next_st.status = gto_pkg::ERR_NONE;
					if (eoi_override == gto_pkg::OVR_DEFAULT)
						next_st.use_eoi = def_eoi;
					else
						next_st.use_eoi = eoi_override == gto_pkg::EOI_ALWAYS;
					if (term1_def) begin
						next_st.term_left = def_term_num;
						next_st.t1 = def_term1;
						next_st.t2 = def_term2;
					end else begin
						next_st.t1 = term1_override[7:0];
						next_st.t2 = term2_override == gto_pkg::OVR_DEFAULT ? def_term2 : term2_override[7:0];
						next_st.term_left = (term2_override == gto_pkg::OVR_DEFAULT && def_term_num < 2'h2)
							? 2'h1 : 2'h2;
					end
					if (next_st.term_left == 2'h1)
						next_st.t2 = next_st.t1;
					if (byte_count == 32'h0) begin
						next_st.fsm = gto_pkg::GTO_DONE;
						next_st.status = gto_pkg::ERR_BAD_COUNT;
						next_st.released = 1'b1;
						next_st.done = 1'b1;
					end else if (is_active_ctl && !skip_addressing && target_count != 4'h0) begin
						next_st.fsm = gto_pkg::GTO_ADDR;
						next_st.atn = 1'b1;
						next_st.ren = is_system_ctl;
					end else begin
						next_st.fsm = gto_pkg::GTO_DATA;
					end
					if (mode[gto_pkg::MODE_CONT_BIT[0]] && !timeout_enable)
						next_st.released = 1'b1;
				end
			end
			default: begin
				// Source handshake: wait NRFD low, drive DAV, wait NDAC high, drop DAV.
				if (!st.dav) begin
					if (st.nrfd_s[1] == 1'b0 && send_ok) begin
						next_st.dio = send_byte;
						next_st.dav = 1'b1;
						next_st.eoi = send_last && st.use_eoi;
						next_st.tmo = '0;
						hs_step = 1'b1;
					end
				end else if (st.ndac_s[1] == 1'b1) begin
					next_st.dav = 1'b0;
					next_st.eoi = 1'b0;
					next_st.tmo = '0;
					hs_step = 1'b1;
					if (st.cont)
						next_st.released = 1'b1;
					if (st.fsm == gto_pkg::GTO_ADDR) begin
						if (!st.talk_sent) begin
							next_st.talk_sent = 1'b1;
						end else if (!st.sec_phase && target_list[st.tgt_idx[3:0]][15:13] == 3'h0) begin
							next_st.sec_phase = 1'b1;
						end else begin
							next_st.sec_phase = 1'b0;
							next_st.tgt_idx = st.tgt_idx + 5'h1;
							if (st.tgt_idx + 5'h1 >= {1'b0, target_count}) begin
								next_st.fsm = gto_pkg::GTO_DATA;
								next_st.atn = 1'b0;
							end
						end
					end else if (st.fsm == gto_pkg::GTO_DATA) begin
						if (st.left == 32'h1) begin
							if (st.reload) begin
								next_st.left = st.total;
							end else if (st.term_left != 2'h0) begin
								next_st.fsm = gto_pkg::GTO_TERM;
								next_st.left = '0;
							end else begin
								next_st.fsm = gto_pkg::GTO_DONE;
								next_st.done = 1'b1;
							end
						end else begin
							next_st.left = st.left - 32'h1;
						end
					end else begin
						next_st.term_left = st.term_left - 2'h1;
						if (st.term_left == 2'h1) begin
							next_st.fsm = gto_pkg::GTO_DONE;
							next_st.done = 1'b1;
						end
					end
				end
				// Waiting on the host FIFO is not a listener stall, so it does not time out.
				if (!hs_step && (st.dav || !need_byte || fifo_valid) && timeout_enable) begin
					next_st.tmo = st.tmo + 32'h1;
					if (st.tmo >= 32'(TIMEOUT_CYCLES - 1)) begin
						next_st.fsm = gto_pkg::GTO_DONE;
						next_st.status = gto_pkg::ERR_TIMEOUT;
						next_st.done = 1'b1;
						next_st.dav = 1'b0;
						next_st.eoi = 1'b0;
						next_st.atn = 1'b0;
					end
				end
				if (halt_transfer_call) begin
					next_st.fsm = gto_pkg::GTO_DONE;
					next_st.status = st.reload ? gto_pkg::ERR_NONE : gto_pkg::ERR_HALTED;
					next_st.done = 1'b1;
					next_st.dav = 1'b0;
					next_st.eoi = 1'b0;
					next_st.atn = 1'b0;
				end
				if (next_st.done)
					next_st.released = 1'b1;
			end
		endcase
	end
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
			st.nrfd_s <= 2'h3;
		end else begin
			st <= next_st;
		end
	end
endmodule

/* File: verif/gto_engine_assertions.sv */
// Purpose: Port-level checks of the talker output engine.
// Assumes: One clock domain, reset active low.
// Notes: Bound from the bench file.
module gto_engine_assertions #(
	parameter int TIMEOUT_CYCLES = 50
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic start,
	input wire logic [31:0] byte_count,
	input wire logic timeout_enable,
	input wire logic busy,
	input wire logic host_release,
	input wire logic done,
	input wire logic [7:0] dio_out,
	input wire logic dio_oe,
	input wire logic dav_out,
	input wire logic eoi_out,
	input wire logic atn_out,
	input wire logic ren_out,
	input wire logic nrfd_in,
	input wire logic ndac_in
);
	// Margin covers the two-flop synchroniser and the abort step.
	localparam int TO_MAX = TIMEOUT_CYCLES + 12;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	a_start_taken: assert property (start && !busy && byte_count != 32'h0 |=> busy) else $error("start not taken");
	a_zero_count: assert property (start && !busy && byte_count == 32'h0 |=> done && !busy)
		else $error("zero count not refused");
	a_byte_hold: assert property (dav_out && $past(dav_out) |-> $stable(dio_out) && $stable(eoi_out)
		&& $stable(atn_out)) else $error("byte changed under DAV");
	a_dav_ready: assert property ($rose(dav_out) |-> !$past(nrfd_in)) else $error("DAV without ready");
	a_dav_accept: assert property ($rose(ndac_in) |-> ##[1:4] !dav_out) else $error("DAV stuck");
	a_done_pulse: assert property (done |=> !done) else $error("done too long");
	a_drive_oe: assert property (dav_out |-> dio_oe && busy) else $error("bus not driven");
	a_ren_hold: assert property ($fell(ren_out) |-> $past(start) || $past(start, 2)) else $error("REN dropped");
	a_eoi_data: assert property (eoi_out |-> !atn_out) else $error("EOI on command");
	a_dav_bound: assert property ($rose(dav_out) && timeout_enable |-> ##[1:TO_MAX] (!dav_out || done))
		else $error("no timeout");
	a_release_end: assert property ($rose(done) |-> ##[0:1] host_release) else $error("host held");
endmodule

/* File: verif/gto_listener_model.sv */
// Purpose: Behavioural GPIB listener answering the engine's handshake.
// Assumes: NRFD and NDAC are active high at the engine's pins.
// Notes: mute never accepts a byte; slow waits 20 cycles per byte.
module gto_listener_model (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [7:0] dio_out,
	input wire logic dav_out,
	input wire logic eoi_out,
	input wire logic atn_out,
	input wire logic mute,
	input wire logic slow,
	output logic nrfd_in,
	output logic ndac_in
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [9:0] seen [$];
	int wt;
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			nrfd_in <= 1'b0;
			ndac_in <= 1'b0;
			wt <= 0;
		end else if (dav_out && !ndac_in && !mute) begin
			if (wt < (slow ? 20 : 1)) begin
				wt <= wt + 1;
			end else begin
				seen.push_back({atn_out, eoi_out, dio_out});
				nrfd_in <= 1'b1;
				ndac_in <= 1'b1;
				wt <= 0;
			end
		end else if (!dav_out && ndac_in) begin
			ndac_in <= 1'b0;
			nrfd_in <= 1'b0;
		end
	end
endmodule

/* File: verif/gpib_talker_output_engine_bench.sv */
// Purpose: Self-checking bench for the talker output engine.
// Assumes: 10 MHz clock, shortened handshake timeout of 50 cycles.
// Notes: Expected bytes are {atn, eoi, data}.
module gpib_talker_output_engine_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk = 0, rst_n = 0, start = 0, dma_auto_reload = 0, halt_transfer_call = 0, timeout_enable = 1;
	logic is_active_ctl = 0, is_system_ctl = 0, skip_addressing = 0, def_eoi = 0, data_valid = 0, mute = 0, slow = 0;
	logic [1:0] mode = 0, def_term_num = 0;
	logic [31:0] byte_count = 0;
	logic [4:0] my_address = 5'h05;
	logic [3:0] target_count = 0;
	logic [15:0] target_list [15];
	logic [15:0] eoi_override = 16'hFFFF, term1_override = 16'hFFFF, term2_override = 16'hFFFF;
	logic [7:0] def_term1 = 0, def_term2 = 0, data_in = 0, status, dio_out;
	logic data_ready, busy, host_release, done, dio_oe, dav_out, eoi_out, atn_out, ren_out, nrfd_in, ndac_in;
	int failures = 0, total_checks = 0;
	logic [9:0] exq [$];
	always #50 core_clk = ~core_clk;
	gto_engine #(.TIMEOUT_CYCLES(50)) uut (.core_clk, .rst_n, .start, .mode, .byte_count, .dma_auto_reload,
		.halt_transfer_call, .timeout_enable, .is_active_ctl, .is_system_ctl, .skip_addressing, .my_address,
		.target_count, .target_list, .eoi_override, .term1_override, .term2_override, .def_eoi, .def_term_num,
		.def_term1, .def_term2, .data_valid, .data_ready, .data_in, .busy, .host_release, .done, .status,
		.dio_out, .dio_oe, .dav_out, .eoi_out, .atn_out, .ren_out, .nrfd_in, .ndac_in);
	gto_listener_model lsn (.core_clk, .rst_n, .dio_out, .dav_out, .eoi_out, .atn_out, .mute, .slow, .nrfd_in,
		.ndac_in);
	// ==========================================================
	// Shared tasks
	task chk(string n, logic [31:0] s, logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	task finish_test;
		$display("checks %0d mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// Data is pushed only after start, because start clears the FIFO.
	task go(logic [1:0] m, logic [31:0] n, int nd);
		lsn.seen.delete();
		@(posedge core_clk);
		mode <= m;
		byte_count <= n;
		start <= 1'b1;
		@(posedge core_clk);
		start <= 1'b0;
		for (int i = 0; i < nd; i++) begin
			data_valid <= 1'b1;
			data_in <= 8'hA0 + 8'(i);
			#1;
			while (data_ready !== 1'b1) begin
				@(posedge core_clk);
				#1;
			end
			@(posedge core_clk);
		end
		if (nd > 0) data_valid <= 1'b0;
	endtask
	task wait_done;
		int k;
		k = 0;
		do begin
			@(posedge core_clk);
			#1;
			k++;
		end while (done !== 1'b1 && k < 3000);
		chk("done", done, 1);
	endtask
	// The abort answers at the edge that samples the request, so done is read right after it.
	task halt_now;
		@(posedge core_clk);
		halt_transfer_call <= 1'b1;
		@(posedge core_clk);
		halt_transfer_call <= 1'b0;
		#1;
		chk("halt done", done, 1);
	endtask
	task cmp_seq;
		chk("count", lsn.seen.size(), exq.size());
		foreach (exq[i]) if (i < lsn.seen.size()) chk("byte", lsn.seen[i], exq[i]);
	endtask
	// ==========================================================
	// Scenarios
	task t_addr;
		@(posedge core_clk);
		{is_active_ctl, is_system_ctl, target_count, eoi_override} <= {2'h3, 4'h2, 16'h0001};
		{def_term_num, def_term1} <= {2'h1, 8'h0A};
		go(2'h0, 32'h3, 3);
		wait_done;
		exq = '{10'h245, 10'h227, 10'h263, 10'h229, 10'h0A0, 10'h0A1, 10'h0A2, 10'h10A};
		cmp_seq;
		chk("ren", ren_out, 1);
		chk("status", status, gto_pkg::ERR_NONE);
		$display("t_addr done");
	endtask
	task t_skip;
		@(posedge core_clk);
		{skip_addressing, def_eoi, def_term_num} <= {2'h3, 2'h0};
		{eoi_override, term1_override, term2_override} <= {16'h0000, 16'h000D, 16'h000A};
		go(2'h1, 32'h2, 2);
		wait_done;
		exq = '{10'h0A0, 10'h0A1, 10'h00D, 10'h00A};
		cmp_seq;
		chk("ren", ren_out, 0);
		$display("t_skip done");
	endtask
	task t_periph;
		@(posedge core_clk);
		{is_active_ctl, skip_addressing, eoi_override, term1_override, term2_override} <= {2'h0, 48'hFFFF_FFFF_0055};
		{def_term_num, def_term1, def_term2} <= {2'h2, 16'h1122};
		go(2'h0, 32'h1, 1);
		wait_done;
		exq = '{10'h0A0, 10'h011, 10'h122};
		cmp_seq;
		$display("t_periph done");
	endtask
	task t_early;
		int k;
		@(posedge core_clk);
		{slow, def_term_num, def_eoi} <= {1'b1, 2'h0, 1'b0};
		go(2'h3, 32'h2, 2);
		for (k = 0; k < 200 && host_release !== 1'b1; k++) @(posedge core_clk) #1;
		chk("release", {busy, host_release, 1'(lsn.seen.size() > 0)}, 3'h7);
		wait_done;
		@(posedge core_clk);
		timeout_enable <= 1'b0;
		go(2'h3, 32'h1, 0);
		@(posedge core_clk) #1;
		chk("release0", {host_release, 1'(lsn.seen.size())}, 2'h2);
		halt_now;
		chk("halted", status, gto_pkg::ERR_HALTED);
		go(2'h0, 32'h0, 0);
		#1;
		chk("zero done", done, 1);
		chk("zero status", status, gto_pkg::ERR_BAD_COUNT);
		{slow, timeout_enable} <= 2'h1;
		$display("t_early done");
	endtask
	task t_fill_timeout;
		int n;
		logic r;
		n = 0;
		@(posedge core_clk);
		mute <= 1'b1;
		go(2'h0, 32'hFFFF_FFFF, 0);
		data_valid <= 1'b1;
		repeat (40) begin
			#1 r = data_ready;
			@(posedge core_clk);
			if (r) n++;
		end
		data_valid <= 1'b0;
		chk("full", {1'(n >= 32 && n <= 33), data_ready}, 2'h2);
		wait_done;
		chk("status", status, gto_pkg::ERR_TIMEOUT);
		mute <= 1'b0;
		$display("t_fill_timeout done");
	endtask
	task t_halt;
		int k;
		@(posedge core_clk);
		dma_auto_reload <= 1'b1;
		go(2'h3, 32'h2, 6);
		for (k = 0; k < 400 && lsn.seen.size() < 4; k++) @(posedge core_clk) #1;
		chk("reload", {busy, 1'(lsn.seen.size() >= 4)}, 2'h3);
		halt_now;
		chk("status", status, gto_pkg::ERR_NONE);
		$display("t_halt done");
	endtask
	initial begin
		foreach (target_list[i]) target_list[i] = 16'h0000;
		target_list[0] = 16'h0307;
		target_list[1] = 16'hE009;
		repeat (12) @(posedge core_clk);
		rst_n <= 1'b1;
		t_addr;
		t_skip;
		t_periph;
		t_early;
		t_fill_timeout;
		t_halt;
		finish_test;
	end
	initial begin
		#(100 * 30000);
		failures++;
		finish_test;
	end
endmodule
bind gto_engine gto_engine_assertions #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) chk_i (.core_clk, .rst_n, .start, .byte_count,
	.timeout_enable, .busy, .host_release, .done, .dio_out, .dio_oe, .dav_out, .eoi_out, .atn_out, .ren_out,
	.nrfd_in, .ndac_in);
